//--- baas_pkg.sv
// package for the byte alu: operation codes, widths, reset values
// assumes nothing beyond a systemverilog compiler
package baas_pkg;
  localparam int DATA_W     = 8;
  localparam int PTR_W      = 16;
  localparam int ADDR_W     = 7;
  localparam int IMM6_W     = 6;
  localparam int NIB_W      = 4;
  localparam int MSB_POS    = 7;
  localparam int PTR_COUNT  = 2;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [PTR_W-1:0]  PTR_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  // target selector values
  localparam logic TARGET_ACC = 1'b0;
  localparam logic TARGET_MEM = 1'b1;
  // operation codes
  typedef enum logic [2:0] {
    BAAS_OP_NONE            = 3'h0,
    BAAS_OP_AND_IMMEDIATE   = 3'h1,
    BAAS_OP_ADD_IMMEDIATE   = 3'h2,
    BAAS_OP_AND_MEMORY      = 3'h3,
    BAAS_OP_ADD_MEMORY      = 3'h4,
    BAAS_OP_ARITH_SHIFT_RIGHT = 3'h5,
    BAAS_OP_ADD_MEMORY_WITH_CARRY = 3'h6,
    BAAS_OP_POINTER_ADD_IMMEDIATE = 3'h7
  } baas_op_type;
endpackage

//--- baas_ptr_store.sv
// pointer pair store: two 16-bit pointers, read data driven straight from the storage registers
// assumes one write per cycle from the alu on the same clock
`timescale 1ns/1ns
module baas_ptr_store
  import baas_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  input  wire logic             wr_en_i,
  input  wire logic             wr_sel_i,
  input  wire logic [PTR_W-1:0] wr_data_i,
  output logic      [PTR_W-1:0] ptr0_o,
  output logic      [PTR_W-1:0] ptr1_o
);
  logic [PTR_W-1:0] mem_reg [PTR_COUNT];

  // storage and combinational read
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mem_reg[0] <= PTR_RESET;
      mem_reg[1] <= PTR_RESET;
    end else if (wr_en_i) begin
      mem_reg[wr_sel_i] <= wr_data_i;
    end
  end

  assign ptr0_o = mem_reg[0];
  assign ptr1_o = mem_reg[1];
endmodule

//--- baas_alu.sv
// byte alu: seven operations on accumulator, memory operand and pointers
// assumes memory data for the given address arrive in the issuing cycle
`timescale 1ns/1ns
module baas_alu
  import baas_pkg::*;
(
  input  wire logic                         clk_i,
  input  wire logic                         srst_i,
  input  wire logic                         op_valid_i,
  input  wire baas_pkg::baas_op_type        op_i,
  input  wire logic [baas_pkg::DATA_W-1:0]  imm_i,
  input  wire logic                         ptr_sel_i,
  input  wire logic [baas_pkg::ADDR_W-1:0]  mem_addr_i,
  input  wire logic [baas_pkg::DATA_W-1:0]  mem_rdata_i,
  input  wire logic                         target_i,
  output logic      [baas_pkg::DATA_W-1:0]  acc_o,
  output logic                              carry_o,
  output logic                              half_sum_overflow_bit_o,
  output logic                              zero_o,
  output logic                              mem_we_o,
  output logic      [baas_pkg::ADDR_W-1:0]  mem_waddr_o,
  output logic      [baas_pkg::DATA_W-1:0]  mem_wdata_o,
  output logic      [baas_pkg::PTR_W-1:0]   pointer_pair0_o,
  output logic      [baas_pkg::PTR_W-1:0]   pointer_pair1_o,
  output logic                              done_o
);
  import baas_pkg::*;

  // 8-bit add with carry in; returns {carry7, half carry, sum}
  function automatic logic [DATA_W+1:0] add8(
    input logic [DATA_W-1:0] a,
    input logic [DATA_W-1:0] b,
    input logic              cin
  );
    logic [NIB_W:0]  lo;
    logic [DATA_W:0] full;
    lo   = {1'b0, a[NIB_W-1:0]} + {1'b0, b[NIB_W-1:0]} + {4'h0, cin};
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    return {full[DATA_W], lo[NIB_W], full[DATA_W-1:0]};
  endfunction

  // a memory-operand op whose selector points back at memory
  function automatic logic dest_is_mem(
    input logic is_mem,
    input logic target
  );
    return is_mem && (target == TARGET_MEM);
  endfunction

  logic [DATA_W-1:0] acc_reg;
  logic              carry_reg;
  logic              half_reg;
  logic              zero_reg;
  logic              mem_we_reg;
  logic [ADDR_W-1:0] mem_waddr_reg;
  logic [DATA_W-1:0] mem_wdata_reg;
  logic              done_reg;
  logic [PTR_W-1:0]  ptr0_w;
  logic [PTR_W-1:0]  ptr1_w;

  // operand selection and arithmetic
  wire [DATA_W-1:0] opnd_w   = (op_i == BAAS_OP_AND_IMMEDIATE ||
                                op_i == BAAS_OP_ADD_IMMEDIATE) ?
                               imm_i : mem_rdata_i;
  wire              cin_w    = (op_i == BAAS_OP_ADD_MEMORY_WITH_CARRY) ?
                               carry_reg : 1'b0;
  wire [DATA_W+1:0] sum_w    = add8(acc_reg, opnd_w, cin_w);
  wire [DATA_W-1:0] and_w    = acc_reg & opnd_w;
  wire [DATA_W-1:0] asr_w    = {mem_rdata_i[MSB_POS],
                                mem_rdata_i[MSB_POS:1]};

  // pointer add: sign extend, 16-bit sum drops the overflow bit
  wire [PTR_W-1:0]  ptr_cur_w = ptr_sel_i ? ptr1_w : ptr0_w;
  wire [PTR_W-1:0]  imm_ext_w = {{(PTR_W-IMM6_W){imm_i[IMM6_W-1]}},
                                 imm_i[IMM6_W-1:0]};
  wire [PTR_W-1:0]  ptr_sum_w = ptr_cur_w + imm_ext_w;
  wire              ptr_we_w  = op_valid_i &&
                                op_i == BAAS_OP_POINTER_ADD_IMMEDIATE;

  // result and flag selection per operation
  logic [DATA_W-1:0] res_w;
  logic              is_mem_w;
  logic              upd_c_w;
  logic              upd_dc_w;
  logic              upd_z_w;
  logic              c_w;
  always_comb begin
    res_w    = ZERO_BYTE;
    is_mem_w = 1'b0;
    upd_c_w  = 1'b0;
    upd_dc_w = 1'b0;
    upd_z_w  = 1'b0;
    c_w      = sum_w[DATA_W+1];
    case (op_i)
      BAAS_OP_AND_IMMEDIATE: begin
        res_w   = and_w;
        upd_z_w = 1'b1;
      end
      BAAS_OP_ADD_IMMEDIATE: begin
        res_w    = sum_w[DATA_W-1:0];
        upd_c_w  = 1'b1;
        upd_dc_w = 1'b1;
        upd_z_w  = 1'b1;
      end
      BAAS_OP_AND_MEMORY: begin
        res_w    = and_w;
        is_mem_w = 1'b1;
        upd_z_w  = 1'b1;
      end
      BAAS_OP_ADD_MEMORY, BAAS_OP_ADD_MEMORY_WITH_CARRY: begin
        res_w    = sum_w[DATA_W-1:0];
        is_mem_w = 1'b1;
        upd_c_w  = 1'b1;
        upd_dc_w = 1'b1;
        upd_z_w  = 1'b1;
      end
      BAAS_OP_ARITH_SHIFT_RIGHT: begin
        res_w    = asr_w;
        is_mem_w = 1'b1;
        upd_c_w  = 1'b1;
        upd_z_w  = 1'b1;
        c_w      = mem_rdata_i[0];
      end
      default: begin
        res_w = ZERO_BYTE; // pointer add and none touch no flag
      end
    endcase
  end

  // issue and result routing
  wire go_w      = op_valid_i && op_i != BAAS_OP_NONE;
  wire to_mem_w  = go_w && dest_is_mem(is_mem_w, target_i);
  wire to_acc_w  = go_w && op_i != BAAS_OP_POINTER_ADD_IMMEDIATE &&
                   !dest_is_mem(is_mem_w, target_i);

  // flag write enables; untouched flags keep their value
  wire upd_carry_w = go_w && upd_c_w;
  wire upd_half_w  = go_w && upd_dc_w;
  wire upd_zero_w  = go_w && upd_z_w;
  wire zero_res_w  = (res_w == ZERO_BYTE); // zero from the routed result

  // accumulator, written only when the result is routed to it
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      acc_reg <= ACC_RESET;
    end else if (to_acc_w) begin
      acc_reg <= res_w;
    end
  end

  // carry: carry out of bit 7, or the bit shifted out
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      carry_reg <= 1'b0;
    end else if (upd_carry_w) begin
      carry_reg <= c_w;
    end
  end

  // half flag: carry out of bit 3, kept by shifts and ands
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      half_reg <= 1'b0;
    end else if (upd_half_w) begin
      half_reg <= sum_w[DATA_W];
    end
  end

  // zero flag: set on an all-zero result, cleared otherwise
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      zero_reg <= 1'b0;
    end else if (upd_zero_w) begin
      zero_reg <= zero_res_w;
    end
  end

  // memory write-back and completion strobe
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mem_we_reg    <= 1'b0;
      mem_waddr_reg <= '0;
      mem_wdata_reg <= ZERO_BYTE;
      done_reg      <= 1'b0;
    end else begin
      mem_we_reg    <= to_mem_w;
      mem_waddr_reg <= mem_addr_i;
      mem_wdata_reg <= res_w;
      done_reg      <= go_w;
    end
  end

  baas_ptr_store u_ptr (
    .clk_i     (clk_i),
    .srst_i    (srst_i),
    .wr_en_i   (ptr_we_w),
    .wr_sel_i  (ptr_sel_i),
    .wr_data_i (ptr_sum_w),
    .ptr0_o    (ptr0_w),
    .ptr1_o    (ptr1_w)
  );

  assign acc_o                   = acc_reg;
  assign carry_o                 = carry_reg;
  assign half_sum_overflow_bit_o = half_reg;
  assign zero_o                  = zero_reg;
  assign mem_we_o                = mem_we_reg;
  assign mem_waddr_o             = mem_waddr_reg;
  assign mem_wdata_o             = mem_wdata_reg;
  assign pointer_pair0_o         = ptr0_w;
  assign pointer_pair1_o         = ptr1_w;
  assign done_o                  = done_reg;
endmodule

//--- baas_alu_checker.sv
// assertions on the byte alu ports, bound into baas_alu
// assumes baas_pkg is compiled first and one clock domain
`timescale 1ns/1ns
module baas_alu_checker
  import baas_pkg::*;
(
  input wire logic                  clk_i,
  input wire logic                  srst_i,
  input wire logic                  op_valid_i,
  input wire baas_pkg::baas_op_type op_i,
  input wire logic [7:0]            imm_i,
  input wire logic                  ptr_sel_i,
  input wire logic [6:0]            mem_addr_i,
  input wire logic [7:0]            mem_rdata_i,
  input wire logic                  target_i,
  input wire logic [7:0]            acc_o,
  input wire logic                  carry_o,
  input wire logic                  half_sum_overflow_bit_o,
  input wire logic                  zero_o,
  input wire logic                  mem_we_o,
  input wire logic [6:0]            mem_waddr_o,
  input wire logic [15:0]           pointer_pair0_o,
  input wire logic                  done_o
);
  import baas_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // an accepted request and its kind
  sequence s_issue;
    op_valid_i && op_i != BAAS_OP_NONE;
  endsequence
  sequence s_op(baas_op_type o);
    op_valid_i && op_i == o;
  endsequence
  chk_done_pulse: assert property (s_issue |=> done_o)
    else $error("done missing after an issued op");
  chk_idle_quiet: assert property (
    !(op_valid_i && op_i != BAAS_OP_NONE)
    |=> !done_o && !mem_we_o && $stable(acc_o))
    else $error("idle cycle changed state");
  chk_ptr_flags: assert property (
    s_op(BAAS_OP_POINTER_ADD_IMMEDIATE)
    |=> $stable({carry_o, half_sum_overflow_bit_o, zero_o}))
    else $error("pointer add touched a flag");
  chk_ptr_wrap: assert property (
    s_op(BAAS_OP_POINTER_ADD_IMMEDIATE) ##0 !ptr_sel_i
    |=> pointer_pair0_o == $past(pointer_pair0_o)
    + {{10{$past(imm_i[5])}}, $past(imm_i[5:0])})
    else $error("pointer 0 sum wrong");
  chk_and_imm: assert property (
    s_op(BAAS_OP_AND_IMMEDIATE)
    |=> acc_o == ($past(acc_o) & $past(imm_i)) && $stable(carry_o)
    && zero_o == (acc_o == 8'h00))
    else $error("and immediate wrong");
  chk_add_imm: assert property (
    s_op(BAAS_OP_ADD_IMMEDIATE)
    |=> {carry_o, acc_o} == $past(acc_o) + $past(imm_i))
    else $error("add immediate wrong");
  chk_mem_target: assert property (
    op_valid_i && target_i
    && op_i >= BAAS_OP_AND_MEMORY && op_i <= BAAS_OP_ADD_MEMORY_WITH_CARRY
    |=> mem_we_o && mem_waddr_o == $past(mem_addr_i) && $stable(acc_o))
    else $error("memory target not written");
  chk_asr_shift: assert property (
    s_op(BAAS_OP_ARITH_SHIFT_RIGHT) ##0 !target_i
    |=> acc_o == {$past(mem_rdata_i[7]), $past(mem_rdata_i[7:1])}
    && carry_o == $past(mem_rdata_i[0]))
    else $error("shift right wrong");
  chk_add_carry: assert property (
    s_op(BAAS_OP_ADD_MEMORY_WITH_CARRY) ##0 !target_i
    |=> {carry_o, acc_o} == $past(acc_o) + $past(mem_rdata_i)
    + $past(carry_o))
    else $error("add with carry wrong");
endmodule
bind baas_alu baas_alu_checker u_baas_alu_checker (.*);

//--- tb_top.sv
// testbench for the byte alu: scripted operations against a model
// assumes baas_pkg and baas_alu are compiled first
`timescale 1ns/1ns
module tb_top;
  import baas_pkg::*;
  logic        clk_i = 0, srst_i = 1, op_valid_i = 0;
  logic        ptr_sel_i = 0, target_i = 0, mem_we_o, done_o;
  baas_op_type op_i = BAAS_OP_NONE;
  logic [7:0]  imm_i = 8'h00, mem_rdata_i = 8'h00, ea = 8'h00;
  logic [7:0]  acc_o, mem_wdata_o;
  logic [6:0]  mem_addr_i = 7'h00, mem_waddr_o;
  logic        carry_o, half_sum_overflow_bit_o, zero_o;
  logic        ec = 0, eh = 0, ez = 0;
  logic [15:0] pointer_pair0_o, pointer_pair1_o, ep0 = 0, ep1 = 0;
  int          mismatches = 0, tests_run = 0;
  always #4 clk_i = ~clk_i;
  baas_alu u_baas_alu (
    .clk_i                   (clk_i),
    .srst_i                  (srst_i),
    .op_valid_i              (op_valid_i),
    .op_i                    (op_i),
    .imm_i                   (imm_i),
    .ptr_sel_i               (ptr_sel_i),
    .mem_addr_i              (mem_addr_i),
    .mem_rdata_i             (mem_rdata_i),
    .target_i                (target_i),
    .acc_o                   (acc_o),
    .carry_o                 (carry_o),
    .half_sum_overflow_bit_o (half_sum_overflow_bit_o),
    .zero_o                  (zero_o),
    .mem_we_o                (mem_we_o),
    .mem_waddr_o             (mem_waddr_o),
    .mem_wdata_o             (mem_wdata_o),
    .pointer_pair0_o         (pointer_pair0_o),
    .pointer_pair1_o         (pointer_pair1_o),
    .done_o                  (done_o)
  );
  // one comparison
  task chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // issue one op, update the model, compare every output (write address and data only on a memory write)
  task automatic go(logic [2:0] c, logic [7:0] k, logic t,
                    logic [7:0] m, logic [6:0] a);
    baas_op_type o;
    logic [8:0]  s;
    logic [4:0]  h;
    logic [7:0]  b, r;
    logic        cin, an, mw;
    o = baas_op_type'(c);
    b = (o <= BAAS_OP_ADD_IMMEDIATE) ? k : m;
    cin = (o == BAAS_OP_ADD_MEMORY_WITH_CARRY) & ec;
    an = o == BAAS_OP_AND_IMMEDIATE || o == BAAS_OP_AND_MEMORY;
    s = ea + b + cin;
    h = ea[3:0] + b[3:0] + cin;
    r = an ? (ea & b) : s[7:0];
    if (o == BAAS_OP_ARITH_SHIFT_RIGHT) r = {m[7], m[7:1]};
    mw = t && o >= BAAS_OP_AND_MEMORY && o <= BAAS_OP_ADD_MEMORY_WITH_CARRY;
    case (o)
      BAAS_OP_NONE: ;
      BAAS_OP_POINTER_ADD_IMMEDIATE: begin
        if (t) ep1 = ep1 + {{10{k[5]}}, k[5:0]};
        else ep0 = ep0 + {{10{k[5]}}, k[5:0]};
      end
      default: begin
        ez = (r == 8'h00);
        if (o == BAAS_OP_ARITH_SHIFT_RIGHT) ec = m[0];
        else if (!an) begin
          ec = s[8];
          eh = h[4];
        end
        if (!mw) ea = r;
      end
    endcase
    @(negedge clk_i);
    {op_valid_i, op_i, imm_i, ptr_sel_i, target_i} = {1'b1, o, k, t, t};
    {mem_rdata_i, mem_addr_i} = {m, a};
    @(negedge clk_i);
    op_valid_i = 0;
    chk(acc_o, ea);
    chk({carry_o, half_sum_overflow_bit_o, zero_o}, {ec, eh, ez});
    chk(pointer_pair0_o, ep0);
    chk(pointer_pair1_o, ep1);
    chk({done_o, mem_we_o}, {o != BAAS_OP_NONE, mw});
    if (mw) chk({mem_waddr_o, mem_wdata_o}, {a, r});
  endtask
  // watchdog well beyond the scripted run
  initial begin
    #5000;
    mismatches++;
    stop_test;
  end
  initial begin
    repeat (20) @(negedge clk_i);
    srst_i = 0;
    go(3'h0, 8'hFF, 1'h1, 8'hFF, 7'h7F);
    go(3'h2, 8'h0F, 1'h0, 8'h00, 7'h00);
    go(3'h2, 8'h01, 1'h1, 8'h00, 7'h00);
    go(3'h2, 8'hF0, 1'h0, 8'h00, 7'h00);
    go(3'h1, 8'hFF, 1'h0, 8'h00, 7'h00);
    go(3'h2, 8'h85, 1'h0, 8'h00, 7'h00);
    $display("immediate ops done");
    go(3'h6, 8'h00, 1'h0, 8'h7A, 7'h12);
    go(3'h4, 8'h00, 1'h1, 8'h01, 7'h7F);
    go(3'h6, 8'h00, 1'h0, 8'h00, 7'h01);
    go(3'h2, 8'hC3, 1'h0, 8'h00, 7'h00);
    go(3'h3, 8'hFF, 1'h1, 8'h0F, 7'h00);
    go(3'h3, 8'h00, 1'h0, 8'h3C, 7'h40);
    go(3'h5, 8'h00, 1'h1, 8'h81, 7'h2A);
    go(3'h5, 8'h00, 1'h0, 8'h02, 7'h15);
    go(3'h4, 8'h00, 1'h0, 8'h0F, 7'h33);
    $display("memory ops done");
    go(3'h7, 8'h3F, 1'h0, 8'h00, 7'h00);
    go(3'h7, 8'h1F, 1'h1, 8'h00, 7'h00);
    go(3'h7, 8'h01, 1'h0, 8'h00, 7'h00);
    go(3'h7, 8'hE0, 1'h1, 8'h00, 7'h00);
    $display("pointer ops done");
    stop_test;
  end
endmodule
